//--- include/pmc_map.vh
// Purpose: Register offsets, field positions, reset values and timing counts of the power mode controller
// Assumes: 10 MHz system clock, 32-bit Avalon-MM register bus with byte addresses
// Notes: Definitions only
`ifndef PMC_MAP_VH
`define PMC_MAP_VH
// Register byte offsets
`define PMC_REG_MODE 4'h0
`define PMC_REG_STATUS 4'h4
`define PMC_REG_RETAIN 4'h8
`define PMC_REG_CAUSE 4'hC
// Mode request codes
`define PMC_MODE_ACTIVE 2'h0
`define PMC_MODE_IDLE 2'h1
`define PMC_MODE_STANDBY 2'h2
`define PMC_MODE_SHUTDOWN 2'h3
// Retention register fields
`define PMC_RET_SRAM_LSB 0
`define PMC_RET_CACHE_BIT 4
`define PMC_RET_FASTSRC_BIT 5
`define PMC_RET_SLOWSRC_BIT 6
`define PMC_RET_RESET 7'h0F
// Reset cause codes
`define PMC_CAUSE_POR 2'h1
`define PMC_CAUSE_PIN 2'h2
`define PMC_CAUSE_WAKE 2'h3
// Wake latencies in microseconds
`define PMC_WAKE_IDLE_US 14
`define PMC_WAKE_STBY_US 151
`define PMC_WAKE_SHDN_US 1015
`define PMC_CLK_MHZ 10
`define PMC_WAKE_IDLE_CYC (`PMC_WAKE_IDLE_US * `PMC_CLK_MHZ)
`define PMC_WAKE_STBY_CYC (`PMC_WAKE_STBY_US * `PMC_CLK_MHZ)
`define PMC_WAKE_SHDN_CYC (`PMC_WAKE_SHDN_US * `PMC_CLK_MHZ)
`endif

//--- verilog/pmc_power_mode_controller.v
// Purpose: Power mode sequencer with clock gating, I/O latching, retention control and reset cause
// Assumes: One 10 MHz clock; wake pins and reset pin are asynchronous and are synchronised here
// Notes: Registers sit on an Avalon-MM slave; waitrequest is low in the cycle after a request arrives
//
// What this block does
// R01: Idle stops CPU and memory clocks only
// R02: Any interrupt returns idle to active
// R03: Standby wakes on pin, RTC or sensor event
// R04: Standby resume keeps CPU and peripheral state
// R05: GPIOs stay latched through all standby
// R06: Shutdown powers all off, I/O latched
// R07: Shutdown wake pin change causes reset
// R08: Reset cause register shows wake, pin, POR
// R09: Shutdown keeps only I/O latch and flash
// R10: Four SRAM blocks, each with retention enable
// R11: Cache becomes RAM when caching disabled
// R12: Wake latency 14, 151, 1015 microseconds
// R13: Registers full, partial, or none retained
// R14: SRAM retained except shutdown and reset hold
// R15: Radio only in active and idle
// R16: Sensor processor on unless shutdown or reset
// R17: RTC wakes from active, idle, standby
// R18: Fast clock off in standby; source selectable
// R19: Fast clock is crystal reference doubled
// R20: Slow RC used without slow crystal
// R21: Always-on domain powered except shutdown
// R22: Sleep only on request; gate before power-off (here io_latch_o and the power-off outputs switch in the same cycle)
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
`include "pmc_map.vh"
module pmc_power_mode_controller #(
  parameter WAKE_IDLE_CYC = `PMC_WAKE_IDLE_CYC,
  parameter WAKE_STBY_CYC = `PMC_WAKE_STBY_CYC,
  parameter WAKE_SHDN_CYC = `PMC_WAKE_SHDN_CYC,
  parameter NUM_WAKE_PINS = 8
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // Avalon-MM register slave
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // Wake sources
  input wire irq_any_i,
  input wire rtc_event_i,
  input wire sensor_event_i,
  input wire [NUM_WAKE_PINS-1:0] wake_pin_i,
  input wire [NUM_WAKE_PINS-1:0] wake_pin_en_i,
  input wire reset_pin_n_i,
  // Clock gates and domain power
  output reg cpu_clk_en_o,
  output reg periph_clk_en_o,
  output reg radio_en_o,
  output reg sensor_en_o,
  output reg always_on_domain_en_o,
  output reg fast_clk_en_o,
  output reg fast_clk_sel_crystal_o,
  output reg fast_clk_doubler_en_o,
  output reg slow_clk_sel_crystal_o,
  output reg io_latch_o,
  output reg [3:0] sram_retain_o,
  output reg sram_power_o,
  output reg cache_as_ram_o,
  output reg reg_retain_partial_o,
  output reg sys_reset_o
);

  // Sequencer states
  localparam ST_ACTIVE = 3'h0;
  localparam ST_IDLE = 3'h1;
  localparam ST_STBY = 3'h2;
  localparam ST_SHDN = 3'h3;
  localparam ST_WAKE = 3'h4;
  localparam ST_RSTHOLD = 3'h5;
  localparam CNT_W = 16;

  reg [2:0] state_q; // Current power state
  reg [CNT_W-1:0] cnt_q; // Wake latency counter
  reg [1:0] req_q; // Pending software mode request
  reg req_vld_q; // Request waiting to be acted on
  reg [6:0] ret_q; // Retention and clock source control
  reg [1:0] cause_q; // Recorded reset cause
  reg ack_q; // Bus answer pending
  reg from_shdn_q; // Wake sequence ends in a system reset
  reg [NUM_WAKE_PINS-1:0] pin_s1_q, pin_s2_q, pin_s3_q; // Wake pin synchroniser
  reg [NUM_WAKE_PINS-1:0] pin_ref_q; // Pin levels latched at shutdown entry
  reg [2:0] rstp_q; // Reset pin synchroniser
  reg rst_held_q; // Filtered reset pin held
  wire [NUM_WAKE_PINS-1:0] pin_stable; // Second and third stages agree
  wire pin_change; // Enabled wake pin moved
  wire rst_assert; // Filtered reset pin asserted

  // Change counts once second and third stage agree
  genvar g;
  generate
    for (g = 0; g < NUM_WAKE_PINS; g = g + 1) begin : g_pin
      assign pin_stable[g] = (pin_s2_q[g] == pin_s3_q[g]);
    end
  endgenerate
  assign pin_change = |(wake_pin_en_i & pin_stable & (pin_s3_q ^ pin_ref_q)); // R07
  assign rst_assert = (rstp_q[1] == rstp_q[2]) ? ~rstp_q[2] : rst_held_q;

  // Input synchronisers
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_q <= {NUM_WAKE_PINS{1'b0}};
      pin_s2_q <= {NUM_WAKE_PINS{1'b0}};
      pin_s3_q <= {NUM_WAKE_PINS{1'b0}};
      rstp_q <= 3'h7;
      rst_held_q <= 1'b0;
    end else begin
      pin_s1_q <= wake_pin_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      rstp_q <= {rstp_q[1:0], reset_pin_n_i};
      rst_held_q <= rst_assert;
    end
  end

  // Bus answer one cycle after the request
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;

  // Register writes, read data and the bus acknowledge
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      avs_readdata_o <= 32'h0;
      ret_q <= `PMC_RET_RESET;
      req_q <= `PMC_MODE_ACTIVE;
      req_vld_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
      // Sequencer consumes the request when it leaves active
      if (state_q != ST_ACTIVE) begin
        req_vld_q <= 1'b0;
      end
      if (state_q == ST_RSTHOLD || (state_q == ST_WAKE && from_shdn_q)) begin
        ret_q <= `PMC_RET_RESET; // R09
      end else if (avs_write_i && ack_q && avs_byteenable_i[0]) begin
        // Write lands at the edge where waitrequest is low
        case (avs_address_i)
          `PMC_REG_MODE: begin
            req_q <= avs_writedata_i[1:0]; // R22
            req_vld_q <= (avs_writedata_i[1:0] != `PMC_MODE_ACTIVE);
          end
          `PMC_REG_RETAIN: begin
            ret_q <= avs_writedata_i[6:0]; // R10
          end
          default: begin
            ret_q <= ret_q;
          end
        endcase
      end
      if (avs_read_i && ~ack_q) begin
        case (avs_address_i)
          `PMC_REG_MODE: avs_readdata_o <= {30'h0, req_q};
          `PMC_REG_STATUS: avs_readdata_o <= {29'h0, state_q};
          `PMC_REG_RETAIN: avs_readdata_o <= {25'h0, ret_q};
          `PMC_REG_CAUSE: avs_readdata_o <= {30'h0, cause_q}; // R08
          default: avs_readdata_o <= 32'h0;
        endcase
      end
    end
  end

  // Power state sequencer
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_ACTIVE;
      cnt_q <= {CNT_W{1'b0}};
      cause_q <= `PMC_CAUSE_POR; // R08
      from_shdn_q <= 1'b0;
      pin_ref_q <= {NUM_WAKE_PINS{1'b0}};
    end else if (rst_assert && state_q != ST_RSTHOLD) begin
      state_q <= ST_RSTHOLD;
    end else begin
      case (state_q)
        ST_ACTIVE: begin
          if (req_vld_q && ack_q == 1'b0) begin
            case (req_q)
              `PMC_MODE_IDLE: state_q <= ST_IDLE; // R22
              `PMC_MODE_STANDBY: state_q <= ST_STBY;
              default: begin
                state_q <= ST_SHDN;
                pin_ref_q <= pin_s3_q; // R06
              end
            endcase
          end
        end
        ST_IDLE: begin
          if (irq_any_i || rtc_event_i) begin // R02 R17
            state_q <= ST_WAKE;
            cnt_q <= WAKE_IDLE_CYC[CNT_W-1:0] - 16'h1; // R12
            from_shdn_q <= 1'b0;
          end
        end
        ST_STBY: begin
          if (pin_change || rtc_event_i || sensor_event_i) begin // R03 R17
            state_q <= ST_WAKE;
            cnt_q <= WAKE_STBY_CYC[CNT_W-1:0] - 16'h1; // R12
            from_shdn_q <= 1'b0; // R04
          end
        end
        ST_SHDN: begin
          if (pin_change) begin // R07
            state_q <= ST_WAKE;
            cnt_q <= WAKE_SHDN_CYC[CNT_W-1:0] - 16'h1; // R12
            from_shdn_q <= 1'b1;
            cause_q <= `PMC_CAUSE_WAKE; // R08
          end
        end
        ST_RSTHOLD: begin
          if (!rst_assert) begin
            state_q <= ST_WAKE;
            cnt_q <= WAKE_SHDN_CYC[CNT_W-1:0] - 16'h1; // R12
            from_shdn_q <= 1'b1;
            cause_q <= `PMC_CAUSE_PIN; // R08
          end
        end
        ST_WAKE: begin
          if (cnt_q == {CNT_W{1'b0}}) begin
            state_q <= ST_ACTIVE;
          end else begin
            cnt_q <= cnt_q - 16'h1;
          end
        end
        default: state_q <= ST_ACTIVE;
      endcase
    end
  end

  // Domain controls decoded from the state and the retention register
  always @* begin
    cpu_clk_en_o = (state_q == ST_ACTIVE); // R01
    periph_clk_en_o = (state_q == ST_ACTIVE) || (state_q == ST_IDLE); // R01
    radio_en_o = (state_q == ST_ACTIVE) || (state_q == ST_IDLE); // R15
    sensor_en_o = (state_q != ST_SHDN) && (state_q != ST_RSTHOLD); // R16
    always_on_domain_en_o = (state_q != ST_SHDN); // R21
    fast_clk_en_o = periph_clk_en_o || (state_q == ST_WAKE); // R18
    fast_clk_sel_crystal_o = ret_q[`PMC_RET_FASTSRC_BIT]; // R18
    fast_clk_doubler_en_o = fast_clk_en_o && ret_q[`PMC_RET_FASTSRC_BIT]; // R19
    slow_clk_sel_crystal_o = ret_q[`PMC_RET_SLOWSRC_BIT]; // R20
    io_latch_o = (state_q == ST_STBY) || (state_q == ST_SHDN); // R05 R06 R22
    sram_power_o = (state_q != ST_SHDN) && (state_q != ST_RSTHOLD); // R14
    sram_retain_o = (state_q == ST_STBY) ? ret_q[3:0] : 4'hF; // R10
    cache_as_ram_o = ret_q[`PMC_RET_CACHE_BIT]; // R11
    reg_retain_partial_o = (state_q == ST_STBY); // R13
    sys_reset_o = (state_q == ST_RSTHOLD) || (state_q == ST_SHDN) ||
                  (state_q == ST_WAKE && from_shdn_q); // R09 R13
  end

endmodule // pmc_power_mode_controller

//--- dv/pmc_power_mode_controller_sva.sv
// Purpose: Assertions on mode outputs and bus handshake
// Assumes: Wake counts 4 and 8 cycles
// Notes: Idle is periph on, cpu off; standby is latch, always-on kept
`timescale 1ns/1ns
module pmc_power_mode_controller_sva (
  // Clock, reset, requests
  input wire clk_sys_i,
  input wire rst_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire irq_any_i,
  input wire rtc_event_i,
  input wire sensor_event_i,
  // Watched outputs
  input wire avs_waitrequest_o,
  input wire cpu_clk_en_o,
  input wire periph_clk_en_o,
  input wire radio_en_o,
  input wire sensor_en_o,
  input wire always_on_domain_en_o,
  input wire fast_clk_en_o,
  input wire io_latch_o,
  input wire sram_power_o,
  input wire sys_reset_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Mode decodes
  wire idle_w = periph_clk_en_o && !cpu_clk_en_o;
  wire stby_w = io_latch_o && always_on_domain_en_o;
  a_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest held");
  a_idle_irq_wake: assert property (idle_w && irq_any_i |=> !cpu_clk_en_o [*3] ##[1:5] cpu_clk_en_o)
    else $error("idle wake bad");
  a_stby_ev_wake: assert property (stby_w && (rtc_event_i || sensor_event_i)
    |=> !cpu_clk_en_o [*6] ##[1:6] cpu_clk_en_o)
    else $error("standby wake bad");
  a_stby_irq_none: assert property (stby_w && irq_any_i && !rtc_event_i && !sensor_event_i |=> stby_w)
    else $error("standby left on irq");
  a_latch_fast_off: assert property (io_latch_o |-> !fast_clk_en_o && !radio_en_o)
    else $error("fast clock on while latched");
  a_shdn_all_off: assert property (!always_on_domain_en_o |-> !sensor_en_o && !sram_power_o && io_latch_o)
    else $error("shutdown not off");
  a_sensor_off_rst: assert property (!sensor_en_o |-> sys_reset_o && !radio_en_o)
    else $error("sensor off outside reset");
  a_sram_pwr_match: assert property (sram_power_o == sensor_en_o)
    else $error("sram power mismatch");
  c_idle: cover property (idle_w);
  c_stby: cover property (stby_w);
  c_shdn: cover property (!always_on_domain_en_o);
endmodule // pmc_power_mode_controller_sva

//--- dv/pmc_pin_model.sv
// Purpose: Pin side model for wake pins and reset pin
// Assumes: Pins change just after a rising edge
// Notes: Pins hold their level between commands
`timescale 1ns/1ns
module pmc_pin_model (
  // Clock and commands
  input wire clk_sys_i,
  input wire flip_i,
  input wire hold_rst_i,
  // Pins
  output reg [7:0] wake_pin_o = 8'h00,
  output reg reset_pin_n_o = 1'b1
);
  // Flip pin 0 on command, hold reset pin low on request
  always @(posedge clk_sys_i) begin
    if (flip_i) begin
      wake_pin_o <= wake_pin_o ^ 8'h01;
    end
    reset_pin_n_o <= !hold_rst_i;
  end
endmodule // pmc_pin_model

//--- dv/pmc_power_mode_controller_test.sv
// Purpose: Directed mode and register test
// Assumes: 10 MHz clock, wake counts 4, 8, 16
// Notes: Outputs are checked at the falling edge
`timescale 1ns/1ns
`include "pmc_map.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; $display("ERROR %0t %h %h", $time, a, b); end end
module pmc_power_mode_controller_test;
  reg clk_sys_i = 1'b0;
  reg rst_i = 1'b1;
  reg [3:0] adr = 4'h0;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wd = 32'h0;
  reg [3:0] be = 4'hF;
  reg [3:0] ev = 4'h0;
  reg hold = 1'b0;
  wire [31:0] rdata;
  wire wreq, cpu, per, rad, sns, always_on_domain, fck, fxs, dbl, sxs, lat, srp, car, rrp, srs, rpn;
  wire [3:0] sret;
  wire [7:0] pins;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int i;
  int k;
  reg [31:0] q;
  always #50 clk_sys_i = !clk_sys_i;
  pmc_power_mode_controller #(.WAKE_IDLE_CYC(4), .WAKE_STBY_CYC(8), .WAKE_SHDN_CYC(16)) pmc_power_mode_controller_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .irq_any_i(ev[0]), .rtc_event_i(ev[1]), .sensor_event_i(ev[2]), .wake_pin_i(pins), .wake_pin_en_i(8'hFF),
    .reset_pin_n_i(rpn), .cpu_clk_en_o(cpu), .periph_clk_en_o(per), .radio_en_o(rad), .sensor_en_o(sns),
    .always_on_domain_en_o(always_on_domain), .fast_clk_en_o(fck), .fast_clk_sel_crystal_o(fxs), .fast_clk_doubler_en_o(dbl),
    .slow_clk_sel_crystal_o(sxs), .io_latch_o(lat), .sram_retain_o(sret), .sram_power_o(srp),
    .cache_as_ram_o(car), .reg_retain_partial_o(rrp), .sys_reset_o(srs));
  pmc_pin_model pmc_pin_model_i (.clk_sys_i(clk_sys_i), .flip_i(ev[3]), .hold_rst_i(hold),
    .wake_pin_o(pins), .reset_pin_n_o(rpn));
  // Verdict and end of run
  task test_done;
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One register access, held until waitrequest is low
  task bus(input [3:0] a, input w, input [31:0] d);
    @(posedge clk_sys_i);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    do @(negedge clk_sys_i); while (wreq !== 1'b0);
    @(posedge clk_sys_i);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(negedge clk_sys_i);
  endtask
  // Wait n edges, then settle
  task cw(input int n);
    repeat (n) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
  // One-cycle wake source pulse
  task pulse(input [3:0] m);
    @(posedge clk_sys_i);
    ev <= m;
    @(posedge clk_sys_i);
    ev <= 4'h0;
  endtask
  // Bounded wait for the CPU clock
  task wait_cpu;
    for (i = 0; i < 60 && cpu !== 1'b1; i++) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
  // Hang guard
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      test_done;
    end
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    cw(1);
    `CHK({cpu, rad, sns, always_on_domain, fck, lat}, 6'h3E)
    bus(`PMC_REG_CAUSE, 1'b0, 32'h0);
    `CHK(q, 32'h1)
    bus(4'h2, 1'b0, 32'h0);
    `CHK(q, 32'h0)
    be <= 4'hE;
    bus(`PMC_REG_RETAIN, 1'b1, 32'h7F);
    be <= 4'hF;
    bus(`PMC_REG_RETAIN, 1'b0, 32'h0);
    `CHK(q, 32'h0F)
    bus(`PMC_REG_RETAIN, 1'b1, 32'h35);
    `CHK({car, fxs, dbl, sxs}, 4'hE)
    bus(`PMC_REG_MODE, 1'b1, {30'h0, `PMC_MODE_IDLE});
    cw(4);
    `CHK({cpu, per, rad, fck}, 4'h7)
    pulse(4'h1);
    wait_cpu;
    `CHK(cpu, 1'b1)
    for (k = 0; k < 3; k++) begin
      bus(`PMC_REG_MODE, 1'b1, {30'h0, `PMC_MODE_STANDBY});
      cw(4);
      `CHK({lat, fck, rad, sns, always_on_domain, rrp, sret}, 10'h275)
      pulse(4'h1);
      cw(12);
      `CHK(cpu, 1'b0)
      pulse(4'h2 << k);
      wait_cpu;
      bus(`PMC_REG_RETAIN, 1'b0, 32'h0);
      `CHK({cpu, q}, {1'b1, 32'h35})
    end
    bus(`PMC_REG_MODE, 1'b1, {30'h0, `PMC_MODE_SHUTDOWN});
    cw(4);
    `CHK({always_on_domain, sns, srp, lat, srs}, 5'h03)
    pulse(4'h8);
    wait_cpu;
    `CHK({cpu, srs}, 2'h2)
    bus(`PMC_REG_CAUSE, 1'b0, 32'h0);
    `CHK(q, 32'h3)
    bus(`PMC_REG_RETAIN, 1'b0, 32'h0);
    `CHK(q & 32'h70, 32'h0)
    @(posedge clk_sys_i);
    hold <= 1'b1;
    cw(8);
    `CHK({cpu, rad, sns, srs}, 4'h1)
    @(posedge clk_sys_i);
    hold <= 1'b0;
    wait_cpu;
    bus(`PMC_REG_CAUSE, 1'b0, 32'h0);
    `CHK(q, 32'h2)
    test_done;
  end
endmodule // pmc_power_mode_controller_test
bind pmc_power_mode_controller pmc_power_mode_controller_sva pmc_power_mode_controller_sva_i (.clk_sys_i, .rst_i,
  .avs_read_i, .avs_write_i, .irq_any_i, .rtc_event_i, .sensor_event_i, .avs_waitrequest_o, .cpu_clk_en_o,
  .periph_clk_en_o, .radio_en_o, .sensor_en_o, .always_on_domain_en_o, .fast_clk_en_o, .io_latch_o,
  .sram_power_o, .sys_reset_o);
